// ### design/usc_consts.vh
/*
 * constants for the low-speed se0 width classifier: register indices,
 * field positions, reset values and line timing figures.
 * assumes a 50 MHz system clock; included by its bare name.
 */
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH

// system clock period in ns
`define USC_CLK_PERIOD_NS 20

// se0 width thresholds in ns
`define USC_SE0_MIN_NS 500
`define USC_SE0_EOP_MAX_NS 2500
`define USC_SE0_RESET_NS 2670

// register indices; byte address is four times the index
`define USC_IDX_USB_STATUS 6'h19
`define USC_IDX_INT_STATUS 6'h1f
`define USC_IDX_INT_CONTROL 6'h20

// usb status register fields
`define USC_ST_EOP_BIT 0
`define USC_ST_FEOP_BIT 2

// interrupt status register fields (write one to clear)
`define USC_IS_SUSPEND_BIT 3
`define USC_IS_RESET_BIT 4
`define USC_IS_RESUME_BIT 5
`define USC_IS_TOKEN_BIT 7

// interrupt control register fields
`define USC_IC_SUSPEND_EN_BIT 3
`define USC_IC_RESET_EN_BIT 4
`define USC_IC_RESUME_EN_BIT 5
`define USC_IC_TOKEN_EN_BIT 6

// reset values
`define USC_USB_STATUS_RST 8'h00
`define USC_INT_STATUS_RST 8'h00
`define USC_INT_CONTROL_RST 8'h00

// axi response codes
`define USC_RESP_OKAY 2'h0
`define USC_RESP_SLVERR 2'h2

`endif

// ### design/usc_se0_classifier.v
/*
 * se0 width classifier for a low-speed usb function, with an axi4-lite
 * register slave and one level interrupt output.
 * assumes the line pair and the receiver phase inputs are synchronous
 * to clock, and that the receiver engine outside drives the phase levels
 * and returns to idle when rx_abort pulses.
 */
`timescale 1ns/1ns
`include "usc_consts.vh"

module usc_se0_classifier #(
	parameter ADDR_W = 8,
	parameter CNT_W = 8,
	parameter RX_TIMEOUT_CYCLES = 500,
	parameter SUSPEND_CYCLES = 150000,
	parameter SUSP_W = 18
) (
	input wire clock,
	input wire resetn,
	input wire line_dp,
	input wire line_dm,
	input wire rx_token_phase,
	input wire rx_packet_phase,
	input wire bus_suspended,
	output reg rx_abort,
	output reg keepalive_seen,
	output reg irq,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// thresholds in cycles: least times round up
	localparam integer SE0_MIN_I =
		(`USC_SE0_MIN_NS + `USC_CLK_PERIOD_NS - 1) / `USC_CLK_PERIOD_NS;
	localparam integer SE0_RESET_I =
		(`USC_SE0_RESET_NS + `USC_CLK_PERIOD_NS - 1) / `USC_CLK_PERIOD_NS;
	localparam [CNT_W-1:0] SE0_MIN_CYC = SE0_MIN_I[CNT_W-1:0];
	localparam [CNT_W-1:0] SE0_RESET_CYC = SE0_RESET_I[CNT_W-1:0];
	localparam [15:0] RX_TIMEOUT = RX_TIMEOUT_CYCLES[15:0];
	localparam [SUSP_W-1:0] SUSPEND_LIMIT = SUSPEND_CYCLES[SUSP_W-1:0];

	reg rst_meta; // first reset synchroniser stage
	reg rst_n; // released reset copy used everywhere

	reg se0_prev; // se0 level one cycle ago
	reg [CNT_W-1:0] se0_cnt; // width of the running se0, saturating
	reg reset_hit; // long se0 already reported in this se0
	reg resume_hit; // suspend wake already reported in this se0
	reg [15:0] rx_timer; // cycles in reception without an eop
	reg rx_done; // timeout already reported for this reception
	reg [SUSP_W-1:0] susp_timer; // idle time since last keep-alive
	reg susp_done; // suspend already reported

	reg eop_flag; // end of packet seen in packet phase
	reg false_eop_error_flag; // reception ended by timeout
	reg token_irq_flag; // eop after token
	reg reset_flag; // bus reset request
	reg resume_flag; // resume request
	reg suspend_flag; // idle long enough to suspend
	reg token_irq_enable;
	reg resume_irq_enable;
	reg bus_reset_irq_enable;
	reg suspend_irq_enable;

	// write channel capture
	reg aw_held;
	reg w_held;
	reg [ADDR_W-1:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire se0 = ~line_dp & ~line_dm; // single ended zero on the pair
	wire receiving = (rx_token_phase | rx_packet_phase) & ~bus_suspended;
	wire idle_state = ~receiving & ~bus_suspended;
	wire se0_end = se0_prev & ~se0; // se0 just released
	// band between min and reset: clean eop or ambiguous, both classed alike
	wire mid_width = (se0_cnt >= SE0_MIN_CYC) && (se0_cnt < SE0_RESET_CYC);

	// classified events, one cycle each
	wire ev_reset = se0 && (se0_cnt == SE0_RESET_CYC - 1'b1) && !reset_hit;
	wire ev_keepalive = se0_end && mid_width && idle_state;
	wire ev_token = se0_end && mid_width && receiving && rx_token_phase;
	wire ev_eop = se0_end && mid_width && receiving && !rx_token_phase;
	wire ev_resume = bus_suspended && se0 && !resume_hit &&
		(se0_cnt == SE0_MIN_CYC - 1'b1);
	wire ev_timeout = receiving && !rx_done && (rx_timer == RX_TIMEOUT - 1'b1);
	wire ev_suspend = idle_state && !susp_done &&
		(susp_timer == SUSPEND_LIMIT - 1'b1);

	// write handshake decode
	wire wr_go = aw_held && w_held && !s_axi_bvalid;
	wire [5:0] wr_idx = aw_addr[7:2];
	wire [5:0] rd_idx = s_axi_araddr[7:2];
	wire wr_lane0 = w_strb[0];
	wire [7:0] wr_byte = w_data[7:0];
	wire clr_status = wr_go && wr_lane0 && (wr_idx == `USC_IDX_USB_STATUS);
	wire clr_int = wr_go && wr_lane0 && (wr_idx == `USC_IDX_INT_STATUS);

	wire [7:0] usb_status_view;
	wire [7:0] int_status_view;
	wire [7:0] int_control_view;
	assign usb_status_view = {5'h00, false_eop_error_flag, 1'b0, eop_flag};
	assign int_status_view = {token_irq_flag, 1'b0, resume_flag, reset_flag,
		suspend_flag, 3'h0};
	assign int_control_view = {1'b0, token_irq_enable, resume_irq_enable,
		bus_reset_irq_enable, suspend_irq_enable, 3'h0};

	// reset release through two flops, assertion stays asynchronous
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// se0 width measurement; saturates so a long reset cannot wrap
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			se0_prev <= 1'b0;
			se0_cnt <= {CNT_W{1'b0}};
			reset_hit <= 1'b0;
			resume_hit <= 1'b0;
		end else begin
			se0_prev <= se0;
			if (!se0) begin
				se0_cnt <= {CNT_W{1'b0}};
				reset_hit <= 1'b0;
				resume_hit <= 1'b0;
			end else begin
				if (se0_cnt != {CNT_W{1'b1}})
					se0_cnt <= se0_cnt + 1'b1;
				if (ev_reset)
					reset_hit <= 1'b1;
				if (ev_resume)
					resume_hit <= 1'b1;
			end
		end
	end

	// reception watchdog: an eop ends it, a short se0 never does
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_timer <= 16'h0000;
			rx_done <= 1'b0;
		end else if (!receiving || ev_token || ev_eop) begin
			rx_timer <= 16'h0000;
			rx_done <= 1'b0;
		end else if (ev_timeout) begin
			rx_done <= 1'b1;
		end else if (!rx_done) begin
			rx_timer <= rx_timer + 16'h0001;
		end
	end

	// suspend timer runs in idle; a keep-alive, reception, a reset-length se0 or a suspended bus reloads it
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			susp_timer <= {SUSP_W{1'b0}};
			susp_done <= 1'b0;
		end else if (ev_keepalive || receiving || ev_reset) begin
			susp_timer <= {SUSP_W{1'b0}};
			susp_done <= 1'b0;
		end else if (bus_suspended) begin
			susp_timer <= {SUSP_W{1'b0}};
		end else if (ev_suspend) begin
			susp_done <= 1'b1;
		end else if (!susp_done) begin
			// a short se0 lands here and leaves the count running
			susp_timer <= susp_timer + 1'b1;
		end
	end

	// sticky status flags; a set in the clearing cycle wins
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			eop_flag <= 1'b0;
			false_eop_error_flag <= 1'b0;
			token_irq_flag <= 1'b0;
			reset_flag <= 1'b0;
			resume_flag <= 1'b0;
			suspend_flag <= 1'b0;
		end else begin
			// packet phase eop
			if (ev_eop)
				eop_flag <= 1'b1;
			else if (clr_status && wr_byte[`USC_ST_EOP_BIT])
				eop_flag <= 1'b0;
			// reception abandoned by timeout
			if (ev_timeout)
				false_eop_error_flag <= 1'b1;
			else if (clr_status && wr_byte[`USC_ST_FEOP_BIT])
				false_eop_error_flag <= 1'b0;
			// token end of packet
			if (ev_token)
				token_irq_flag <= 1'b1;
			else if (clr_int && wr_byte[`USC_IS_TOKEN_BIT])
				token_irq_flag <= 1'b0;
			// long se0 in any state, suspend included
			if (ev_reset)
				reset_flag <= 1'b1;
			else if (clr_int && wr_byte[`USC_IS_RESET_BIT])
				reset_flag <= 1'b0;
			// se0 activity while suspended
			if (ev_resume)
				resume_flag <= 1'b1;
			else if (clr_int && wr_byte[`USC_IS_RESUME_BIT])
				resume_flag <= 1'b0;
			if (ev_suspend)
				suspend_flag <= 1'b1;
			else if (clr_int && wr_byte[`USC_IS_SUSPEND_BIT])
				suspend_flag <= 1'b0;
		end
	end

	// event pulses to the receiver engine
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_abort <= 1'b0;
			keepalive_seen <= 1'b0;
		end else begin
			rx_abort <= ev_timeout;
			keepalive_seen <= ev_keepalive;
		end
	end

	// interrupt enables, written through lane zero
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			token_irq_enable <= |(`USC_INT_CONTROL_RST & (8'h01 << `USC_IC_TOKEN_EN_BIT));
			resume_irq_enable <= |(`USC_INT_CONTROL_RST & (8'h01 << `USC_IC_RESUME_EN_BIT));
			bus_reset_irq_enable <= |(`USC_INT_CONTROL_RST & (8'h01 << `USC_IC_RESET_EN_BIT));
			suspend_irq_enable <= |(`USC_INT_CONTROL_RST & (8'h01 << `USC_IC_SUSPEND_EN_BIT));
		end else if (wr_go && wr_lane0 && (wr_idx == `USC_IDX_INT_CONTROL)) begin
			token_irq_enable <= wr_byte[`USC_IC_TOKEN_EN_BIT];
			resume_irq_enable <= wr_byte[`USC_IC_RESUME_EN_BIT];
			bus_reset_irq_enable <= wr_byte[`USC_IC_RESET_EN_BIT];
			suspend_irq_enable <= wr_byte[`USC_IC_SUSPEND_EN_BIT];
		end
	end

	// one level interrupt, registered so it is glitch free at the pin
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= (token_irq_flag & token_irq_enable) |
				(resume_flag & resume_irq_enable) |
				(reset_flag & bus_reset_irq_enable) |
				(suspend_flag & suspend_irq_enable);
	end

	// write address and data are taken independently, in either order
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= {ADDR_W{1'b0}};
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready;
			s_axi_wready <= !w_held && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	// write response one cycle after both halves are held
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `USC_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			// unmapped words answer slverr and change nothing
			if (wr_idx == `USC_IDX_USB_STATUS || wr_idx == `USC_IDX_INT_STATUS ||
				wr_idx == `USC_IDX_INT_CONTROL)
				s_axi_bresp <= `USC_RESP_OKAY;
			else
				s_axi_bresp <= `USC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read path: one read at a time, data held until rready
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `USC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid;
			if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid)
				s_axi_arready <= 1'b1;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `USC_RESP_OKAY;
				case (rd_idx)
				`USC_IDX_USB_STATUS: begin
					s_axi_rdata <= {24'h000000, usb_status_view};
				end
				`USC_IDX_INT_STATUS: begin
					s_axi_rdata <= {24'h000000, int_status_view};
				end
				`USC_IDX_INT_CONTROL: begin
					s_axi_rdata <= {24'h000000, int_control_view};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `USC_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // usc_se0_classifier

// ### verification/usc_se0_classifier_assertions.sv
/* port-level checks for the se0 classifier.
   assumes one clock domain and a bind from the bench top file. */
`timescale 1ns/1ns
module usc_chk #(parameter RX_TIMEOUT_CYCLES = 500) (
	input wire clock,
	input wire resetn,
	input wire line_dp,
	input wire line_dm,
	input wire rx_token_phase,
	input wire rx_packet_phase,
	input wire bus_suspended,
	input wire rx_abort,
	input wire keepalive_seen,
	input wire irq,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid
);
	wire se0 = !line_dp && !line_dm; // both lines low
	reg se0_q; // se0 one cycle ago
	reg [7:0] run; // length of the se0 in progress, saturating
	reg [7:0] last_len; // length of the last finished se0
	reg [7:0] ctl; // shadow of the enable register
	reg [15:0] rx_cnt; // cycles spent inside a reception
	wire se0_end = !se0 && se0_q;
	// line and bus history; the bench offers aw and w together
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			se0_q <= 1'b0;
			run <= 8'h00;
			last_len <= 8'h00;
			ctl <= 8'h00;
			rx_cnt <= 16'h0000;
		end else begin
			se0_q <= se0;
			run <= !se0 ? 8'h00 : (run == 8'hff ? run : run + 8'h01);
			if (se0_end) last_len <= run;
			rx_cnt <= (rx_token_phase || rx_packet_phase) ? rx_cnt + 16'h0001 : 16'h0000;
			if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
				&& s_axi_awaddr == 8'h80) ctl <= s_axi_wdata[7:0];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	a_abort_pulse: assert property (rx_abort |=> !rx_abort)
		else $error("rx_abort wider than one cycle");
	a_keepalive_pulse: assert property (keepalive_seen |=> !keepalive_seen)
		else $error("keepalive_seen wider than one cycle");
	// band is 25..133 cycles, ambiguous widths included
	a_keepalive_width: assert property (keepalive_seen |->
		last_len >= 8'h19 && last_len <= 8'h85) else $error("keep-alive on wrong width");
	a_keepalive_idle: assert property (keepalive_seen |-> !rx_token_phase
		&& !rx_packet_phase && !bus_suspended) else $error("keep-alive outside idle");
	a_abort_timeout: assert property (rx_abort |-> rx_cnt >= RX_TIMEOUT_CYCLES - 1
		&& rx_cnt <= RX_TIMEOUT_CYCLES + 4) else $error("rx_abort off the timeout");
	// only a register write may drop the request line
	a_irq_fall: assert property ($fell(irq) |-> $past(s_axi_bvalid))
		else $error("irq fell without a write");
	a_reset_irq: assert property ((run == 8'h86 && ctl[4]) |-> ##[1:6] irq)
		else $error("no irq after reset-length se0");
	a_token_irq: assert property ((se0_end && run >= 8'h19 && run <= 8'h85
		&& rx_token_phase && !bus_suspended && ctl[6]) |-> ##[1:6] irq) else $error("no token irq");
	a_resume_irq: assert property ((bus_suspended && run == 8'h19 && ctl[5])
		|-> ##[1:6] irq) else $error("no resume irq");
endmodule // usc_chk

// ### verification/usc_host_model.sv
/* low-speed host line driver for the classifier bench.
   assumes the caller runs in the clock domain of the design. */
`timescale 1ns/1ns
module usc_host_model (
	input wire clock,
	output reg line_dp,
	output reg line_dm
);
	// idle is the j state: at low speed d- sits high
	initial begin
		line_dp = 1'b0;
		line_dm = 1'b1;
	end
	// data bits as j/k toggles, then an se0 of len cycles, then j
	task send(input int bits, input int len);
		repeat (bits) begin
			@(posedge clock);
			line_dp <= ~line_dp;
			line_dm <= ~line_dm;
		end
		@(posedge clock);
		line_dp <= 1'b0;
		line_dm <= 1'b0;
		repeat (len) @(posedge clock);
		line_dp <= 1'b0;
		line_dm <= 1'b1;
	endtask
endmodule // usc_host_model

// ### verification/usc_se0_classifier_tb.sv
/* self-checking bench: axi4-lite master, host line model, corner and random se0 widths.
   assumes design, checker and host model are compiled first. */
`timescale 1ns/1ns
`include "usc_consts.vh"
module usc_se0_classifier_tb;
	localparam [7:0] A_ST = 8'h04 * `USC_IDX_USB_STATUS; // usb status
	localparam [7:0] A_IS = 8'h04 * `USC_IDX_INT_STATUS; // interrupt status
	localparam [7:0] A_IC = 8'h04 * `USC_IDX_INT_CONTROL; // interrupt enables
	localparam int SUSP = 300; // short idle limit so the suspend request shows quickly
	localparam [1:0] OK = `USC_RESP_OKAY;
	localparam [1:0] ERR = `USC_RESP_SLVERR;
	reg clock = 1'b0, resetn = 1'b0;
	reg rx_token_phase = 1'b0, rx_packet_phase = 1'b0, bus_suspended = 1'b0;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg [31:0] s_axi_wdata = 32'h00000000, seed = 32'hc142f4a6;
	reg [3:0] s_axi_wstrb = 4'h0;
	wire line_dp, line_dm, rx_abort, keepalive_seen, irq, s_axi_awready, s_axi_wready;
	wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int err_total = 0, checks_done = 0, ka = 0, ab = 0, i, len, k, n;
	int corner[4] = '{24, 25, 133, 1}; // edges of the keep-alive band
	int lens[6] = '{30, 30, 130, 130, 10, 10}; // token then packet, per width
	always #10 clock = ~clock;
	// count the one-cycle pulses
	always @(posedge clock) begin
		ka <= ka + keepalive_seen;
		ab <= ab + rx_abort;
	end
	// short timeout so a false eop shows quickly
	usc_se0_classifier #(.RX_TIMEOUT_CYCLES(200), .SUSPEND_CYCLES(SUSP)) usc_se0_classifier_i (
		.clock, .resetn, .line_dp, .line_dm, .rx_token_phase, .rx_packet_phase,
		.bus_suspended, .rx_abort, .keepalive_seen, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	usc_host_model usc_host_model_i (.clock, .line_dp, .line_dm);
	function [31:0] xs(input [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	function [31:0] exp_ka(input int w);
		return (w >= 25 && w <= 133) ? 32'h1 : 32'h0;
	endfunction
	// short se0 in reception: false eop; packet eop: eop flag; token eop: none
	function [31:0] exp_st(input int w, input int tok);
		return w < 25 ? 32'h4 : (tok ? 32'h0 : 32'h1);
	endfunction
	task chk(input [31:0] seen, input [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		if (n == 50) begin
			err_total++;
			wrap_up;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task rd_chk(input [7:0] a, input [31:0] e, input [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		if (n == 50) begin
			err_total++;
			wrap_up;
		end
		s_axi_rready <= 1'b0;
		// the idle suspend flag depends on bench pacing, so it is left out
		chk(s_axi_rdata & (a == A_IS ? 32'hfffffff7 : 32'hffffffff), e);
		chk(s_axi_rresp, er);
	endtask
	task se0(input int bits, input int w);
		usc_host_model_i.send(bits, w);
		repeat (10) @(posedge clock);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		rd_chk(A_ST, 32'h0, OK);
		rd_chk(A_IS, 32'h0, OK);
		rd_chk(A_IC, 32'h0, OK);
		rd_chk(8'h10, 32'h0, ERR);
		wr(8'h10, 32'hff, ERR);
		wr(A_IC, 32'hffff0070, OK);
		rd_chk(A_IC, 32'h70, OK);
		for (i = 0; i < 12; i++) begin
			seed = xs(seed);
			len = i < 4 ? corner[i] : seed % 133 + 1;
			k = ka;
			se0(0, len);
			chk(ka - k, exp_ka(len));
		end
		rd_chk(A_IS, 32'h0, OK);
		k = ka;
		se0(0, 134);
		rd_chk(A_IS, 32'h10, OK);
		chk(irq, 32'h1);
		chk(ka - k, 32'h0);
		wr(A_IS, 32'h10, OK);
		repeat (2) @(posedge clock);
		chk(irq, 32'h0);
		wr(A_IC, 32'h60, OK); // reset request masked
		se0(0, 150);
		chk(irq, 32'h0);
		rd_chk(A_IS, 32'h10, OK);
		wr(A_IC, 32'h70, OK);
		repeat (2) @(posedge clock);
		chk(irq, 32'h1);
		wr(A_IS, 32'hff, OK);
		for (i = 0; i < 6; i++) begin
			seed = xs(seed);
			rx_token_phase <= (i % 2 == 0);
			rx_packet_phase <= (i % 2 == 1);
			k = ab;
			se0(2 * (seed % 4), lens[i]);
			for (n = 0; n < 300 && lens[i] < 25 && ab == k; n++) @(posedge clock);
			rx_token_phase <= 1'b0;
			rx_packet_phase <= 1'b0;
			chk(ab - k, lens[i] < 25);
			rd_chk(A_ST, exp_st(lens[i], i % 2 == 0), OK);
			rd_chk(A_IS, (lens[i] > 24 && i % 2 == 0) ? 32'h80 : 32'h0, OK);
			chk(irq, lens[i] > 24 && i % 2 == 0);
			wr(A_ST, 32'hff, OK);
			wr(A_IS, 32'hff, OK);
		end
		bus_suspended <= 1'b1;
		se0(0, 30);
		rd_chk(A_IS, 32'h20, OK);
		chk(irq, 32'h1);
		se0(0, 140);
		rd_chk(A_IS, 32'h30, OK);
		bus_suspended <= 1'b0;
		wr(A_IS, 32'hff, OK);
		repeat (2) @(posedge clock);
		chk(irq, 32'h0);
		// idle count: a keep-alive restarts it, a short se0 must not
		wr(A_IC, 32'h08, OK);
		se0(0, 30);
		se0(0, 10);
		for (n = 0; n < 400 && !irq; n++) @(posedge clock);
		chk(n >= SUSP - 40 && n <= SUSP - 20, 32'h1);
		wrap_up;
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clock);
		err_total++;
		wrap_up;
	end
endmodule // usc_se0_classifier_tb
bind usc_se0_classifier usc_chk #(.RX_TIMEOUT_CYCLES(RX_TIMEOUT_CYCLES)) usc_chk_i (
	.clock, .resetn, .line_dp, .line_dm, .rx_token_phase, .rx_packet_phase, .bus_suspended,
	.rx_abort, .keepalive_seen, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
